// ### src/ptmr_pkg.sv
package ptmr_pkg;

  // Timer word width
  localparam int CNT_W = 16;

  // Control word field positions
  localparam int CTL_W            = 16;
  localparam int BIT_CLK_SRC      = 1;
  localparam int BIT_COMBINE      = 3;
  localparam int BIT_PRE_LO       = 4;
  localparam int BIT_PRE_HI       = 5;
  localparam int BIT_GATE         = 6;
  localparam int BIT_HALT_IDLE    = 13;
  localparam int BIT_ON           = 15;

  // Prescale divide factors per ratio code
  localparam int PRE_DIV_0 = 1;
  localparam int PRE_DIV_1 = 8;
  localparam int PRE_DIV_2 = 64;
  localparam int PRE_DIV_3 = 256;
  localparam int PRE_W     = 8;

  // Reset values
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [PRE_W-1:0] PRE_RST = 8'h00;

  // Priority code that disables a source
  localparam logic [2:0] PRIO_OFF = 3'h0;

  // Operating modes
  typedef enum logic [1:0] {
    PTMR_MODE_TIMER,
    PTMR_MODE_GATED,
    PTMR_MODE_COUNTER
  } ptmr_mode_t;

endpackage

// ### src/ptmr_prescale.sv
`timescale 1ns/10ps
// Divides a stream of input ticks by the selected ratio
module ptmr_prescale (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  // Control
  input  wire logic       run_i,
  input  wire logic [1:0] ratio_i,
  // Ticks
  input  wire logic       tick_i,
  output logic            tick_o
);

  logic [ptmr_pkg::PRE_W-1:0] cnt_reg;
  logic [ptmr_pkg::PRE_W-1:0] cnt_next;
  logic [ptmr_pkg::PRE_W-1:0] last_w;
  logic                       wrap_w;

  // Terminal prescale count per ratio code
  assign last_w = (ratio_i == 2'h0) ? ptmr_pkg::PRE_W'(ptmr_pkg::PRE_DIV_0 - 1)
                : (ratio_i == 2'h1) ? ptmr_pkg::PRE_W'(ptmr_pkg::PRE_DIV_1 - 1)
                : (ratio_i == 2'h2) ? ptmr_pkg::PRE_W'(ptmr_pkg::PRE_DIV_2 - 1)
                :                     ptmr_pkg::PRE_W'(ptmr_pkg::PRE_DIV_3 - 1);
  assign wrap_w = tick_i && (cnt_reg == last_w);
  assign tick_o = run_i && wrap_w;

  // Cleared while stopped so a restart begins a full period
  assign cnt_next = !run_i ? ptmr_pkg::PRE_RST
                  : wrap_w ? ptmr_pkg::PRE_RST
                  : tick_i ? cnt_reg + 8'h01
                  : cnt_reg;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cnt_reg <= ptmr_pkg::PRE_RST;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

endmodule

// ### src/ptmr_pair.sv
`timescale 1ns/10ps
// Function
// R1: Each timer runs as plain timer, gated timer or synchronous counter.
// R2: Timer and gated modes count the instruction-cycle clock.
// R3: Counter mode counts rising edges of the timer's own count pin.
// R4: Clock source at control bit 1, gate enable at control bit 6.
// R5: Source 0 gate 0 timer, gate 1 gated, source 1 counter.
// R6: Software clears the combine bit for separate 16-bit use.
// R7: Two-bit prescale ratio per timer, set before turning on.
// R8: Writable 16-bit period per timer, loaded before turning on.
// R9: Interrupt enable and three-bit priority per timer.
// R10: Software sets the on bit only after all other setup.
// R11: Only the first pair may raise DMA triggers.
// R12: Combine bit 3 of the lower control word forms 32 bits.
// R13: Upper timer holds high word, lower holds low word.
// R14: In 32-bit mode only lower controls count, except upper idle halt.
// R15: 32-bit mode uses upper interrupt enable, flag and priority.
// R16: Pairs are lower-numbered low word with next higher high word.
// R17: 32-bit timer supports the same three modes.
// R18: 32-bit period splits high word upper, low word lower.
// R19: Count increments per prescaled tick, wraps to zero after period.
// R20: Gated mode counts only while gate input is high.
module ptmr_pair #(
  parameter bit DMA_CAPABLE = 1'b1
) (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // Core idle state
  input  wire logic        idle_mode_i,
  // Lower timer control and period
  input  wire logic [15:0] ctl_lo_i,
  input  wire logic [15:0] period_value_lo_i,
  input  wire logic        period_irq_enable_lo_i,
  input  wire logic [2:0]  period_irq_priority_lo_i,
  input  wire logic        irq_flag_clear_lo_i,
  // Upper timer control and period
  input  wire logic [15:0] ctl_hi_i,
  input  wire logic [15:0] period_value_hi_i,
  input  wire logic        period_irq_enable_hi_i,
  input  wire logic [2:0]  period_irq_priority_hi_i,
  input  wire logic        irq_flag_clear_hi_i,
  // External count and gate pins
  input  wire logic        external_count_pin_lo_i,
  input  wire logic        external_count_pin_hi_i,
  // Count values
  output logic [15:0]      count_lo_o,
  output logic [15:0]      count_hi_o,
  // Interrupt status
  output logic             irq_flag_lo_o,
  output logic             irq_flag_hi_o,
  output logic             irq_req_lo_o,
  output logic             irq_req_hi_o,
  output logic [2:0]       irq_priority_lo_o,
  output logic [2:0]       irq_priority_hi_o,
  // DMA triggers
  output logic             dma_trigger_lo_o,
  output logic             dma_trigger_hi_o
);

  // Pin synchronisers and edge history
  logic [1:0] pin_lo_sync_reg;
  logic [1:0] pin_hi_sync_reg;
  logic       pin_lo_prev_reg;
  logic       pin_hi_prev_reg;

  // Count, flag and output state
  logic [15:0] cnt_lo_reg;
  logic [15:0] cnt_lo_next;
  logic [15:0] cnt_hi_reg;
  logic [15:0] cnt_hi_next;
  logic        flag_lo_reg;
  logic        flag_lo_next;
  logic        flag_hi_reg;
  logic        flag_hi_next;
  logic        req_lo_reg;
  logic        req_hi_reg;
  logic [2:0]  prio_lo_reg;
  logic [2:0]  prio_hi_reg;
  logic        dma_lo_reg;
  logic        dma_hi_reg;

  // Control word decode
  logic       src_lo_w;
  logic       gate_lo_w;
  logic       on_lo_w;
  logic       halt_lo_w;
  logic [1:0] pre_lo_w;
  logic       src_hi_w;
  logic       gate_hi_w;
  logic       on_hi_w;
  logic       halt_hi_w;
  logic [1:0] pre_hi_w;
  logic       wide_w;

  assign src_lo_w  = ctl_lo_i[ptmr_pkg::BIT_CLK_SRC];   // see R4
  assign gate_lo_w = ctl_lo_i[ptmr_pkg::BIT_GATE];      // see R4
  assign on_lo_w   = ctl_lo_i[ptmr_pkg::BIT_ON];
  assign halt_lo_w = ctl_lo_i[ptmr_pkg::BIT_HALT_IDLE];
  assign pre_lo_w  = ctl_lo_i[ptmr_pkg::BIT_PRE_HI:ptmr_pkg::BIT_PRE_LO];
  assign src_hi_w  = ctl_hi_i[ptmr_pkg::BIT_CLK_SRC];
  assign gate_hi_w = ctl_hi_i[ptmr_pkg::BIT_GATE];
  assign on_hi_w   = ctl_hi_i[ptmr_pkg::BIT_ON];
  assign halt_hi_w = ctl_hi_i[ptmr_pkg::BIT_HALT_IDLE];
  assign pre_hi_w  = ctl_hi_i[ptmr_pkg::BIT_PRE_HI:ptmr_pkg::BIT_PRE_LO];
  assign wide_w    = ctl_lo_i[ptmr_pkg::BIT_COMBINE];   // see R12, R16

  // Mode decode, gate ignored when source selects the pin
  ptmr_pkg::ptmr_mode_t mode_lo_w;
  ptmr_pkg::ptmr_mode_t mode_hi_w;
  assign mode_lo_w = src_lo_w  ? ptmr_pkg::PTMR_MODE_COUNTER   // see R5
                   : gate_lo_w ? ptmr_pkg::PTMR_MODE_GATED
                   :             ptmr_pkg::PTMR_MODE_TIMER;
  assign mode_hi_w = src_hi_w  ? ptmr_pkg::PTMR_MODE_COUNTER   // see R5
                   : gate_hi_w ? ptmr_pkg::PTMR_MODE_GATED
                   :             ptmr_pkg::PTMR_MODE_TIMER;

  // Synchronised pin levels and rising edges
  logic pin_lo_w;
  logic pin_hi_w;
  logic rise_lo_w;
  logic rise_hi_w;
  assign pin_lo_w  = pin_lo_sync_reg[1];
  assign pin_hi_w  = pin_hi_sync_reg[1];
  assign rise_lo_w = pin_lo_w && !pin_lo_prev_reg;
  assign rise_hi_w = pin_hi_w && !pin_hi_prev_reg;

  // Raw input ticks per mode
  logic raw_lo_w;
  logic raw_hi_w;
  always_comb begin
    unique case (mode_lo_w)
      ptmr_pkg::PTMR_MODE_TIMER:   raw_lo_w = 1'b1;       // see R1, R2
      ptmr_pkg::PTMR_MODE_GATED:   raw_lo_w = pin_lo_w;   // see R2, R20
      ptmr_pkg::PTMR_MODE_COUNTER: raw_lo_w = rise_lo_w;  // see R3
      default:                     raw_lo_w = 1'b0;
    endcase
  end

  always_comb begin
    unique case (mode_hi_w)
      ptmr_pkg::PTMR_MODE_TIMER:   raw_hi_w = 1'b1;       // see R1, R2
      ptmr_pkg::PTMR_MODE_GATED:   raw_hi_w = pin_hi_w;   // see R2, R20
      ptmr_pkg::PTMR_MODE_COUNTER: raw_hi_w = rise_hi_w;  // see R3
      default:                     raw_hi_w = 1'b0;
    endcase
  end

  // Run enables; in wide mode upper keeps only its idle halt
  logic run_lo_w;
  logic run_hi_w;
  logic run_wide_w;
  assign run_wide_w = on_lo_w && !(idle_mode_i && halt_hi_w);  // see R14
  assign run_lo_w   = wide_w ? run_wide_w
                    : on_lo_w && !(idle_mode_i && halt_lo_w);
  assign run_hi_w   = !wide_w && on_hi_w && !(idle_mode_i && halt_hi_w);

  // Prescalers, one per timer; lower drives the wide timer
  logic tick_lo_w;
  logic tick_hi_w;
  ptmr_prescale u_pre_lo (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .run_i     (run_lo_w),
    .ratio_i   (pre_lo_w),                                // see R7
    .tick_i    (raw_lo_w),
    .tick_o    (tick_lo_w)
  );
  ptmr_prescale u_pre_hi (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .run_i     (run_hi_w),
    .ratio_i   (pre_hi_w),                                // see R7
    .tick_i    (raw_hi_w),
    .tick_o    (tick_hi_w)
  );

  // Period matches, separate and combined
  logic [31:0] cnt_wide_w;
  logic [31:0] per_wide_w;
  logic        match_lo_w;
  logic        match_hi_w;
  logic        match_wide_w;
  assign cnt_wide_w   = {cnt_hi_reg, cnt_lo_reg};                  // see R13
  assign per_wide_w   = {period_value_hi_i, period_value_lo_i};    // see R18
  assign match_lo_w   = cnt_lo_reg == period_value_lo_i;           // see R8
  assign match_hi_w   = cnt_hi_reg == period_value_hi_i;           // see R8
  assign match_wide_w = cnt_wide_w == per_wide_w;

  // Period events per timer
  logic evt_lo_w;
  logic evt_hi_w;
  logic evt_wide_w;
  assign evt_wide_w = wide_w && tick_lo_w && match_wide_w;         // see R17
  assign evt_lo_w   = !wide_w && tick_lo_w && match_lo_w;
  assign evt_hi_w   = (!wide_w && tick_hi_w && match_hi_w) || evt_wide_w;

  // Next count values
  logic [31:0] inc_wide_w;
  assign inc_wide_w = match_wide_w ? 32'h0000_0000 : cnt_wide_w + 32'h1;
  always_comb begin
    cnt_lo_next = cnt_lo_reg;
    cnt_hi_next = cnt_hi_reg;
    if (wide_w) begin
      if (tick_lo_w) begin
        cnt_lo_next = inc_wide_w[15:0];                            // see R19
        cnt_hi_next = inc_wide_w[31:16];                           // see R13
      end
    end else begin
      if (tick_lo_w) begin
        cnt_lo_next = match_lo_w ? ptmr_pkg::CNT_RST
                                 : cnt_lo_reg + 16'h0001;          // see R19
      end
      if (tick_hi_w) begin
        cnt_hi_next = match_hi_w ? ptmr_pkg::CNT_RST
                                 : cnt_hi_reg + 16'h0001;          // see R19
      end
    end
  end

  // Flags: a new event beats a clear in the same cycle
  assign flag_lo_next = evt_lo_w || (flag_lo_reg && !irq_flag_clear_lo_i);
  assign flag_hi_next = evt_hi_w || (flag_hi_reg && !irq_flag_clear_hi_i);

  // Requests gated by enable and nonzero priority
  logic req_lo_next;
  logic req_hi_next;
  assign req_lo_next = !wide_w && flag_lo_next                 // see R15
                     && period_irq_enable_lo_i                 // see R9
                     && (period_irq_priority_lo_i != ptmr_pkg::PRIO_OFF);
  assign req_hi_next = flag_hi_next                            // see R15
                     && period_irq_enable_hi_i                 // see R9
                     && (period_irq_priority_hi_i != ptmr_pkg::PRIO_OFF);

  // Pin synchronisers
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pin_lo_sync_reg <= 2'h0;
      pin_hi_sync_reg <= 2'h0;
      pin_lo_prev_reg <= 1'b0;
      pin_hi_prev_reg <= 1'b0;
    end else begin
      pin_lo_sync_reg <= {pin_lo_sync_reg[0], external_count_pin_lo_i};
      pin_hi_sync_reg <= {pin_hi_sync_reg[0], external_count_pin_hi_i};
      pin_lo_prev_reg <= pin_lo_w;
      pin_hi_prev_reg <= pin_hi_w;
    end
  end

  // Counts and flags
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cnt_lo_reg  <= ptmr_pkg::CNT_RST;
      cnt_hi_reg  <= ptmr_pkg::CNT_RST;
      flag_lo_reg <= 1'b0;
      flag_hi_reg <= 1'b0;
    end else begin
      cnt_lo_reg  <= cnt_lo_next;
      cnt_hi_reg  <= cnt_hi_next;
      flag_lo_reg <= flag_lo_next;
      flag_hi_reg <= flag_hi_next;
    end
  end

  // Interrupt and DMA outputs
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      req_lo_reg  <= 1'b0;
      req_hi_reg  <= 1'b0;
      prio_lo_reg <= ptmr_pkg::PRIO_OFF;
      prio_hi_reg <= ptmr_pkg::PRIO_OFF;
      dma_lo_reg  <= 1'b0;
      dma_hi_reg  <= 1'b0;
    end else begin
      req_lo_reg  <= req_lo_next;
      req_hi_reg  <= req_hi_next;
      prio_lo_reg <= period_irq_priority_lo_i;
      prio_hi_reg <= period_irq_priority_hi_i;
      dma_lo_reg  <= DMA_CAPABLE && evt_lo_w;                       // see R11
      dma_hi_reg  <= DMA_CAPABLE && evt_hi_w;                       // see R11
    end
  end

  // Output drive
  assign count_lo_o        = cnt_lo_reg;
  assign count_hi_o        = cnt_hi_reg;
  assign irq_flag_lo_o     = flag_lo_reg;
  assign irq_flag_hi_o     = flag_hi_reg;
  assign irq_req_lo_o      = req_lo_reg;
  assign irq_req_hi_o      = req_hi_reg;
  assign irq_priority_lo_o = prio_lo_reg;
  assign irq_priority_hi_o = prio_hi_reg;
  assign dma_trigger_lo_o  = dma_lo_reg;
  assign dma_trigger_hi_o  = dma_hi_reg;

endmodule

// ### sim/ptmr_pair_asserts.sv
`timescale 1ns/10ps
// Watches the timer pair ports for stepping, wrap and event behaviour
module ptmr_pair_asserts #(
  parameter bit DMA_CAPABLE = 1'b1
) (
  // Clock, reset and idle
  input wire logic        sys_clk_i, rst_n_i, idle_mode_i,
  // Lower timer inputs
  input wire logic [15:0] ctl_lo_i, period_value_lo_i,
  input wire logic        period_irq_enable_lo_i, irq_flag_clear_lo_i,
  input wire logic [2:0]  period_irq_priority_lo_i,
  // Upper timer inputs
  input wire logic [15:0] ctl_hi_i, period_value_hi_i,
  input wire logic        period_irq_enable_hi_i, irq_flag_clear_hi_i,
  input wire logic [2:0]  period_irq_priority_hi_i,
  // Pins
  input wire logic        external_count_pin_lo_i, external_count_pin_hi_i,
  // Design outputs
  input wire logic [15:0] count_lo_o, count_hi_o,
  input wire logic        irq_flag_lo_o, irq_flag_hi_o, irq_req_lo_o,
  input wire logic        irq_req_hi_o, dma_trigger_lo_o, dma_trigger_hi_o,
  input wire logic [2:0]  irq_priority_lo_o, irq_priority_hi_o
);
  // Running configurations at ratio one
  wire logic        run16 = ctl_lo_i[15] && ctl_lo_i[6:1] == 6'h00 &&
                            !(idle_mode_i && ctl_lo_i[13]);
  wire logic        run32 = ctl_lo_i[15] && ctl_lo_i[6:1] == 6'h04 &&
                            !(idle_mode_i && ctl_hi_i[13]);
  wire logic        gated = ctl_lo_i[15] && ctl_lo_i[6:1] == 6'h20;
  wire logic [31:0] cnt32 = {count_hi_o, count_lo_o};
  wire logic [31:0] per32 = {period_value_hi_i, period_value_lo_i};

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Configuration settled, or gate held low
  sequence s_run16; run16 [*2]; endsequence
  sequence s_run32; run32 [*2]; endsequence
  sequence s_gate_low; (gated && !external_count_pin_lo_i) [*6]; endsequence

  property p_inc16;
    s_run16 ##0 (count_lo_o != period_value_lo_i) |=>
      (count_lo_o - $past(count_lo_o)) == 16'h0001;
  endproperty
  a_inc16: assert property (p_inc16) else $error("no step");
  property p_wrap16;
    s_run16 ##0 (count_lo_o == period_value_lo_i) |=> count_lo_o == 16'h0000
      && irq_flag_lo_o && dma_trigger_lo_o == DMA_CAPABLE;
  endproperty
  a_wrap16: assert property (p_wrap16) else $error("no wrap");
  property p_inc32;
    s_run32 ##0 (cnt32 != per32) |=> (cnt32 - $past(cnt32)) == 32'h00000001;
  endproperty
  a_inc32: assert property (p_inc32) else $error("no step32");
  property p_wrap32;
    s_run32 ##0 (cnt32 == per32) |=> cnt32 == 32'h00000000 &&
      irq_flag_hi_o && dma_trigger_hi_o == DMA_CAPABLE;
  endproperty
  a_wrap32: assert property (p_wrap32) else $error("no wide wrap");
  property p_wide_lo;
    ctl_lo_i[3] |=> !irq_req_lo_o && !dma_trigger_lo_o;
  endproperty
  a_wide_lo: assert property (p_wide_lo) else $error("low event");
  property p_off;
    !ctl_lo_i[15] |=> $stable(count_lo_o);
  endproperty
  a_off: assert property (p_off) else $error("count moved off");
  property p_gate;
    s_gate_low |=> $stable(count_lo_o);
  endproperty
  a_gate: assert property (p_gate) else $error("gate ignored");
  property p_clear;
    irq_flag_clear_lo_i |=> !irq_flag_lo_o || dma_trigger_lo_o || !DMA_CAPABLE;
  endproperty
  a_clear: assert property (p_clear) else $error("flag kept");
  property p_sticky;
    irq_flag_hi_o && !irq_flag_clear_hi_i |=> irq_flag_hi_o;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");
endmodule

// ### sim/ptmr_pin_model.sv
`timescale 1ns/10ps
// Drives one external count pin: a held level or a burst of pulses
module ptmr_pin_model #(
  parameter int PERIOD = 4
) (
  // Timing reference and commands
  input  wire logic sys_clk_i,
  input  wire logic pulse_i,
  input  wire logic level_i,
  // Pin toward the timer
  output wire logic pin_o
);
  int unsigned phase = 0;
  // Pulse train phase, restarted at every burst
  always @(posedge sys_clk_i) begin
    phase <= pulse_i ? (phase + 1) % PERIOD : 0;
  end
  // Pin moves off the edge; still at the level between bursts
  assign #7 pin_o = pulse_i ? (phase >= PERIOD / 2) : level_i;
endmodule

// ### sim/ptmr_pair_tb_top.sv
`timescale 1ns/10ps
// Self-checking bench for the timer pair
module ptmr_pair_tb_top;
  // Design ports
  logic        sys_clk_i = 1'b0, rst_n_i = 1'b0, idle_mode_i = 1'b0;
  logic [15:0] ctl_lo_i = 16'h0000, ctl_hi_i = 16'h0000;
  logic [15:0] period_value_lo_i = 16'h0000, period_value_hi_i = 16'h0000;
  logic        period_irq_enable_lo_i = 1'b1, period_irq_enable_hi_i = 1'b1;
  logic [2:0]  period_irq_priority_lo_i = 3'h0;
  logic [2:0]  period_irq_priority_hi_i = 3'h3;
  logic        irq_flag_clear_lo_i = 1'b0, irq_flag_clear_hi_i = 1'b0;
  logic        external_count_pin_lo_i, external_count_pin_hi_i = 1'b0;
  logic [15:0] count_lo_o, count_hi_o;
  logic        irq_flag_lo_o, irq_flag_hi_o, irq_req_lo_o, irq_req_hi_o;
  logic        dma_trigger_lo_o, dma_trigger_hi_o;
  logic [2:0]  irq_priority_lo_o, irq_priority_hi_o;
  // Bench state
  logic        pulse = 1'b0, level = 1'b0;
  logic        dma_off_lo, dma_off_hi;
  int          n_fail = 0, checks_done = 0, cycles = 0;
  int          div_tab [4] = '{ptmr_pkg::PRE_DIV_0, ptmr_pkg::PRE_DIV_1,
                               ptmr_pkg::PRE_DIV_2, ptmr_pkg::PRE_DIV_3};

  ptmr_pair #(.DMA_CAPABLE(1'b1)) dut_u (.*);
  ptmr_pin_model #(.PERIOD(4)) pin_u (.sys_clk_i(sys_clk_i), .pulse_i(pulse),
    .level_i(level), .pin_o(external_count_pin_lo_i));
  // Second pair on the same stimulus, without the DMA path
  ptmr_pair #(.DMA_CAPABLE(1'b0)) nodma_u (
    .sys_clk_i, .rst_n_i, .idle_mode_i, .ctl_lo_i, .period_value_lo_i,
    .period_irq_enable_lo_i, .period_irq_priority_lo_i, .irq_flag_clear_lo_i,
    .ctl_hi_i, .period_value_hi_i, .period_irq_enable_hi_i,
    .period_irq_priority_hi_i, .irq_flag_clear_hi_i,
    .external_count_pin_lo_i, .external_count_pin_hi_i,
    .count_lo_o(), .count_hi_o(), .irq_flag_lo_o(), .irq_flag_hi_o(),
    .irq_req_lo_o(), .irq_req_hi_o(), .irq_priority_lo_o(),
    .irq_priority_hi_o(), .dma_trigger_lo_o(dma_off_lo),
    .dma_trigger_hi_o(dma_off_hi));

  // Clock and hang guard
  initial begin
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic go(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  // Reset with the lower timer off
  task automatic do_reset();
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    ctl_lo_i <= 16'h0000;
    repeat (6) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
  endtask
  // Period and setup first, on bit one edge later
  task automatic setup(input logic [15:0] ctl, input logic [15:0] per);
    @(posedge sys_clk_i);
    ctl_lo_i <= ctl & 16'h7FFF;
    period_value_lo_i <= per;
    @(posedge sys_clk_i);
    ctl_lo_i <= ctl;
  endtask

  initial begin
    // Timer mode: wrap, events, clear and clear against event
    do_reset();
    period_irq_priority_lo_i <= 3'h5;
    setup(16'h8000, 16'h0002);
    go(3);
    chk("count", count_lo_o, 32'h0);
    chk("flag", irq_flag_lo_o, 32'h1);
    chk("req", irq_req_lo_o, 32'h1);
    chk("dma", dma_trigger_lo_o, 32'h1);
    chk("no dma", dma_off_lo, 32'h0);
    chk("prio", irq_priority_lo_o, 32'h5);
    @(posedge sys_clk_i);
    irq_flag_clear_lo_i <= 1'b1;
    go(1);
    chk("cleared", irq_flag_lo_o, 32'h0);
    chk("dma end", dma_trigger_lo_o, 32'h0);
    @(posedge sys_clk_i);
    irq_flag_clear_lo_i <= 1'b0;
    #1;
    chk("event wins", irq_flag_lo_o, 32'h1);
    // Every ratio code: four ticks in four divide periods
    for (int code = 0; code < 4; code++) begin
      do_reset();
      setup(16'h8000 | (16'(code) << 4), 16'hFFFF);
      go(4 * div_tab[code]);
      chk("prescale", count_lo_o, 32'h4);
    end
    // Gated: only cycles with the pin high count
    do_reset();
    setup(16'h8040, 16'hFFFF);
    go(20);
    chk("gate low", count_lo_o, 32'h0);
    @(posedge sys_clk_i);
    level <= 1'b1;
    repeat (20) @(posedge sys_clk_i);
    level <= 1'b0;
    go(10);
    chk("gate high", count_lo_o, 32'h14);
    // Counter mode, gate bit set but ignored: ten pin edges
    do_reset();
    setup(16'h8042, 16'hFFFF);
    @(posedge sys_clk_i);
    pulse <= 1'b1;
    repeat (40) @(posedge sys_clk_i);
    pulse <= 1'b0;
    go(10);
    chk("counter", count_lo_o, 32'hA);
    // Upper alone, gated by its own pin: four high cycles wrap period 3
    do_reset();
    period_value_hi_i <= 16'h0003;
    @(posedge sys_clk_i);
    ctl_hi_i <= 16'h8040;
    @(posedge sys_clk_i);
    external_count_pin_hi_i <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    external_count_pin_hi_i <= 1'b0;
    go(4);
    chk("hi count", count_hi_o, 32'h0);
    chk("hi flag", irq_flag_hi_o, 32'h1);
    chk("hi req", irq_req_hi_o, 32'h1);
    chk("hi prio", irq_priority_hi_o, 32'h3);
    chk("lo still", count_lo_o, 32'h0);
    // Wide: upper word carries, upper halt and events apply
    do_reset();
    ctl_hi_i <= 16'h2032;
    period_value_hi_i <= 16'h0001;
    setup(16'h8008, 16'h0002);
    go(65536);
    chk("wide step", {count_hi_o, count_lo_o}, 32'h00010000);
    @(posedge sys_clk_i);
    idle_mode_i <= 1'b1;
    repeat (10) @(posedge sys_clk_i);
    idle_mode_i <= 1'b0;
    #1;
    chk("idle halt", {count_hi_o, count_lo_o}, 32'h00010001);
    go(2);
    chk("wide wrap", {count_hi_o, count_lo_o}, 32'h0);
    chk("flag hi", irq_flag_hi_o, 32'h1);
    chk("req hi", irq_req_hi_o, 32'h1);
    chk("req lo", irq_req_lo_o, 32'h0);
    chk("dma hi", dma_trigger_hi_o, 32'h1);
    chk("no dma hi", dma_off_hi, 32'h0);
    close_out();
  end
endmodule

bind ptmr_pair ptmr_pair_asserts #(.DMA_CAPABLE(DMA_CAPABLE)) chk_u (.*);
